// ===== shared/canphy_defines.svh
`ifndef CANPHY_DEFINES_SVH
`define CANPHY_DEFINES_SVH

// register byte addresses on the wishbone slave
`define ADDR_FAULT_FLAGS     8'h00
`define ADDR_CONTROL         8'h04
`define ADDR_STATUS          8'h08
`define ADDR_TIMEOUT_CYCLES  8'h0c

// fault flag bit positions
`define FLAG_DT   3
`define FLAG_HOC  1
`define FLAG_LOC  0
`define FLAGS_RESET 8'h00

// control bit positions
`define CTRL_PHY_EN   0
`define CTRL_WAKE_LO  1
`define CTRL_WAKE_HI  2

// wake filter encodings
`define WAKE_OFF     2'h0
`define WAKE_MASK1   2'h1
`define WAKE_TRANSP  2'h2
`define WAKE_MASK2   2'h3

// timing, clock in MHz
`define CLK_MHZ                200
`define DT_TIME_US             1000
`define DT_CYCLES_DEFAULT      (`DT_TIME_US * `CLK_MHZ)
`define REENABLE_TIME_US       1
`define REENABLE_CYCLES        (`REENABLE_TIME_US * `CLK_MHZ)
`define RETRY_FLAG_TIME_US     2
`define RETRY_FLAG_CYCLES      (`RETRY_FLAG_TIME_US * `CLK_MHZ)
`define WAKE_MIN_TIME_US       1
`define WAKE_MIN_CYCLES        (`WAKE_MIN_TIME_US * `CLK_MHZ)

`endif

// ===== shared/canphy_pkg.sv
package canphy_pkg;

	typedef enum {
		M_SHUTDOWN,
		M_NORMAL,
		M_PSEUDO,
		M_LISTEN,
		M_STANDBY
	} phy_mode_t;

	typedef enum {
		W_IDLE,
		W_DOM,
		W_REC
	} wake_state_t;

	typedef struct packed {
		logic dom_drive;
		logic high_drv_en;
		logic low_drv_en;
	} tx_drive_t;

	typedef struct packed {
		logic hi_voltage_fail;
		logic low_line_undervoltage_status;
		logic high_line_undervolt;
		logic high_overcurrent;
		logic low_overcurrent;
	} bus_monitor_t;

endpackage

// ===== rtl/can_phy_mode_fault_control.sv
`timescale 1ns/1ps
`include "canphy_defines.svh"
// How it works
// - tx dominant past timeout sets flag bit 3 and enters listen-only.
// - clear while tx dominant or status active keeps listen-only, flag re-set later.
// - high-line overcurrent while dominant sets bit 1; listen-only while set.
// - low-line overcurrent while dominant sets bit 0; listen-only while set.
// - reset enters shutdown with transceiver and monitors off.
// - shutdown is never re-entered except by reset.
// - normal drives bus from tx, reports bus on rx, monitors on.
// - tx high gives recessive, tx low dominant with both drivers.
// - rx high for recessive bus, low for dominant bus.
// - high voltage fail, overcurrent or timeout moves normal to listen-only.
// - low-line undervoltage gives pseudo-normal; high-line undervoltage keeps normal.
// - pseudo-normal disables only low driver; returns once undervoltage clears.
// - listen-only forces transmitter off, keeps reception and monitors.
// - voltage-caused listen-only returns to normal when condition passes.
// - timeout flag clear is honoured only once tx is recessive.
// - stop request in reduced performance enters standby; monitors off, counter frozen.
// - standby ends when reduced performance mode ends.
// - wake enabled in standby sources rx from wake receiver.
// - pulse filter holds rx recessive until one or two wake events.
// - wake event is dominant then recessive, each at least minimum time.
// - after wake-up the mode before stop is restored.
// - filter select: 0 off, b10 transparent, b01 mask one, b11 mask two.
// - writing one clears a fault flag, zero leaves it.
module can_phy_mode_fault_control
	import canphy_pkg::*;
#(
	parameter logic [31:0] DT_CYCLES = `DT_CYCLES_DEFAULT
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// protocol controller side
	input  wire logic        phy_tx_input_i,
	output logic             phy_rx_output_o,
	// analog front end
	input  wire logic        bus_dominant_i,
	input  wire logic        wake_rx_dominant_i,
	input  wire bus_monitor_t monitor_i,
	output tx_drive_t        tx_drive_o,
	// device power state
	input  wire logic        reduced_performance_mode_i,
	input  wire logic        stop_request_i
);

	// two-flop synchronisers for every asynchronous input
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	assign raw_in = {phy_tx_input_i, bus_dominant_i, wake_rx_dominant_i, monitor_i,
		reduced_performance_mode_i, stop_request_i};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= raw_in[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	logic         tx_rec;
	logic         bus_dom;
	logic         wake_dom;
	bus_monitor_t mon;
	logic         reduced_performance_mode;
	logic         stop_req;
	// tx idles high (recessive); reset value 0 is corrected within two cycles
	assign {tx_rec, bus_dom, wake_dom, mon, reduced_performance_mode, stop_req} = sync2_reg;

	// register state
	logic [7:0]  flags_reg;
	logic        phy_en_reg;
	logic [1:0]  wake_filter_select_reg;
	logic [31:0] dt_limit_reg;
	phy_mode_t   mode_reg;
	phy_mode_t   saved_mode_reg;
	logic        dominant_timeout_status_reg;
	logic [31:0] dt_cnt_reg;
	logic [15:0] reenable_cnt_reg;
	logic        reenable_pend_reg;
	logic [15:0] retry_cnt_reg;
	logic        retry_pend_reg;
	logic        dominant_timeout_status_next;

	// bus decode
	logic bus_req;
	logic wr_strobe;
	assign bus_req   = cyc_i & stb_i & ~ack_o;
	// writes land on the edge where the master sees ack, while it still holds the request
	assign wr_strobe = cyc_i & stb_i & we_i & ack_o;

	logic flag_clr_wr;
	logic [7:0] flag_clr_mask;
	assign flag_clr_wr   = wr_strobe && adr_i == `ADDR_FAULT_FLAGS && sel_i[0];
	assign flag_clr_mask = flag_clr_wr ? dat_i[7:0] : 8'h00;

	logic monitors_on;
	logic driving_dom;
	assign monitors_on = mode_reg == M_NORMAL || mode_reg == M_PSEUDO || mode_reg == M_LISTEN;
	assign driving_dom = ~tx_rec && (mode_reg == M_NORMAL || mode_reg == M_PSEUDO);

	// counter holds at one below the limit, so status stays set until tx turns recessive
	logic dt_fire;
	assign dt_fire = monitors_on && ~tx_rec && dt_cnt_reg >= dt_limit_reg - 32'h1;

	logic dt_clear_try;
	assign dt_clear_try = flag_clr_mask[`FLAG_DT] && flags_reg[`FLAG_DT];

	// wishbone ack and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= bus_req;
			if (bus_req && !we_i) begin
				case (adr_i)
					`ADDR_FAULT_FLAGS:    dat_o <= {24'h0, flags_reg};
					`ADDR_CONTROL:        dat_o <= {29'h0, wake_filter_select_reg, phy_en_reg};
					`ADDR_STATUS:         dat_o <= {24'h0, 3'h0, mon.low_line_undervoltage_status,
						dominant_timeout_status_reg, 3'(mode_reg)};
					`ADDR_TIMEOUT_CYCLES: dat_o <= dt_limit_reg;
					default:              dat_o <= 32'h0;
				endcase
			end
		end
	end

	// control registers; phy enable is sticky
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phy_en_reg             <= 1'b0;
			wake_filter_select_reg <= `WAKE_OFF;
			dt_limit_reg           <= 32'h0;
		end else if (wr_strobe && adr_i == `ADDR_CONTROL && sel_i[0]) begin
			phy_en_reg             <= phy_en_reg | dat_i[`CTRL_PHY_EN];
			wake_filter_select_reg <= dat_i[`CTRL_WAKE_HI:`CTRL_WAKE_LO];
		end else if (wr_strobe && adr_i == `ADDR_TIMEOUT_CYCLES && sel_i == 4'hf) begin
			dt_limit_reg <= dat_i;
		end else if (dt_limit_reg == 32'h0) begin
			dt_limit_reg <= DT_CYCLES;
		end
	end

	// dominant timeout counter, frozen outside monitored modes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dt_cnt_reg <= 32'h0;
		end else if (tx_rec && monitors_on) begin
			dt_cnt_reg <= 32'h0;
		end else if (monitors_on && ~dt_fire) begin
			dt_cnt_reg <= dt_cnt_reg + 32'h1;
		end
	end

	always_comb begin
		dominant_timeout_status_next = dominant_timeout_status_reg;
		if (dt_fire) begin
			dominant_timeout_status_next = 1'b1;
		end else if (tx_rec && monitors_on) begin
			dominant_timeout_status_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dominant_timeout_status_reg <= 1'b0;
		end else begin
			dominant_timeout_status_reg <= dominant_timeout_status_next;
		end
	end

	// fault flags: hardware set wins over a one-write clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_reg <= `FLAGS_RESET;
		end else begin
			flags_reg <= flags_reg & ~(flag_clr_mask & ((8'h1 << `FLAG_HOC) | (8'h1 << `FLAG_LOC)));
			if (dt_clear_try && tx_rec && ~dominant_timeout_status_reg) begin
				flags_reg[`FLAG_DT] <= 1'b0;
			end
			if (dt_fire || (retry_pend_reg && retry_cnt_reg == 16'h0)) begin
				flags_reg[`FLAG_DT] <= 1'b1;
			end
			if (driving_dom && mon.high_overcurrent) begin
				flags_reg[`FLAG_HOC] <= 1'b1;
			end
			if (driving_dom && mon.low_overcurrent) begin
				flags_reg[`FLAG_LOC] <= 1'b1;
			end
		end
	end

	// failed clear attempts re-raise the flag after a delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			retry_pend_reg <= 1'b0;
			retry_cnt_reg  <= 16'h0;
		end else if (dt_clear_try && (~tx_rec || dominant_timeout_status_reg)) begin
			retry_pend_reg <= 1'b1;
			retry_cnt_reg  <= 16'(`RETRY_FLAG_CYCLES - 1);
		end else if (retry_pend_reg) begin
			if (retry_cnt_reg == 16'h0) begin
				retry_pend_reg <= 1'b0;
			end else begin
				retry_cnt_reg <= retry_cnt_reg - 16'h1;
			end
		end
	end

	// successful clear: hold listen-only for the re-enable delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reenable_pend_reg <= 1'b0;
			reenable_cnt_reg  <= 16'h0;
		end else if (dt_clear_try && tx_rec && ~dominant_timeout_status_reg) begin
			reenable_pend_reg <= 1'b1;
			reenable_cnt_reg  <= 16'(`REENABLE_CYCLES - 1);
		end else if (reenable_pend_reg) begin
			if (reenable_cnt_reg == 16'h0) begin
				reenable_pend_reg <= 1'b0;
			end else begin
				reenable_cnt_reg <= reenable_cnt_reg - 16'h1;
			end
		end
	end

	// mode machine
	// listen-only outranks pseudo-normal: a fault that kills the driver beats a half driver
	logic listen_cause;
	assign listen_cause = mon.hi_voltage_fail | flags_reg[`FLAG_HOC] | flags_reg[`FLAG_LOC]
		| flags_reg[`FLAG_DT] | dt_fire | reenable_pend_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg       <= M_SHUTDOWN;
			saved_mode_reg <= M_NORMAL;
		end else begin
			case (mode_reg)
				M_SHUTDOWN: begin
					if (phy_en_reg) begin
						mode_reg <= M_NORMAL;
					end
				end
				M_NORMAL, M_PSEUDO, M_LISTEN: begin
					if (reduced_performance_mode && stop_req) begin
						saved_mode_reg <= mode_reg;
						mode_reg       <= M_STANDBY;
					end else if (listen_cause) begin
						mode_reg <= M_LISTEN;
					end else if (mon.low_line_undervoltage_status) begin
						mode_reg <= M_PSEUDO;
					end else begin
						mode_reg <= M_NORMAL;
					end
				end
				M_STANDBY: begin
					if (~reduced_performance_mode) begin
						mode_reg <= saved_mode_reg;
					end
				end
				default: mode_reg <= M_SHUTDOWN;
			endcase
		end
	end

	// wake pulse filter, counts events since standby entry
	wake_state_t wake_state_reg;
	logic [15:0] wake_time_reg;
	logic [1:0]  wake_events_reg;
	logic [1:0]  wake_needed;
	assign wake_needed = wake_filter_select_reg == `WAKE_MASK2 ? 2'h2 :
		wake_filter_select_reg == `WAKE_MASK1 ? 2'h1 : 2'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i || mode_reg != M_STANDBY) begin
			wake_state_reg  <= W_IDLE;
			wake_time_reg   <= 16'h0;
			wake_events_reg <= 2'h0;
		end else begin
			case (wake_state_reg)
				W_IDLE: begin
					wake_time_reg <= 16'h0;
					if (wake_dom) begin
						wake_state_reg <= W_DOM;
					end
				end
				W_DOM: begin
					if (wake_dom) begin
						// saturate so a stuck dominant wake line cannot wrap into a short pulse
						if (wake_time_reg != 16'hffff) begin
							wake_time_reg <= wake_time_reg + 16'h1;
						end
					end else if (wake_time_reg >= 16'(`WAKE_MIN_CYCLES - 1)) begin
						wake_state_reg <= W_REC;
						wake_time_reg  <= 16'h0;
					end else begin
						wake_state_reg <= W_IDLE;
					end
				end
				W_REC: begin
					if (wake_dom) begin
						wake_state_reg <= W_DOM;
						wake_time_reg  <= 16'h0;
					end else if (wake_time_reg >= 16'(`WAKE_MIN_CYCLES - 1)) begin
						wake_state_reg <= W_IDLE;
						if (wake_events_reg != 2'h2) begin
							wake_events_reg <= wake_events_reg + 2'h1;
						end
					end else begin
						wake_time_reg <= wake_time_reg + 16'h1;
					end
				end
				default: wake_state_reg <= W_IDLE;
			endcase
		end
	end

	// outputs
	logic      tx_active;
	tx_drive_t drive_next;
	assign tx_active = mode_reg == M_NORMAL || mode_reg == M_PSEUDO;
	always_comb begin
		drive_next.dom_drive   = tx_active && ~tx_rec;
		drive_next.high_drv_en = drive_next.dom_drive;
		drive_next.low_drv_en  = drive_next.dom_drive && mode_reg == M_NORMAL;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_drive_o      <= '0;
			phy_rx_output_o <= 1'b1;
		end else begin
			tx_drive_o <= drive_next;
			if (mode_reg == M_STANDBY) begin
				if (wake_filter_select_reg == `WAKE_OFF || wake_events_reg < wake_needed) begin
					phy_rx_output_o <= 1'b1;
				end else begin
					phy_rx_output_o <= ~wake_dom;
				end
			end else if (mode_reg == M_SHUTDOWN) begin
				phy_rx_output_o <= 1'b1;
			end else begin
				phy_rx_output_o <= ~bus_dom;
			end
		end
	end

endmodule

// ===== testbench/can_ctrl_model.sv
`timescale 1ns/1ps
module can_ctrl_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// bench requests
	input  wire logic       send_i,
	input  wire logic [7:0] len_i,
	input  wire logic       clr_i,
	// phy side
	input  wire logic       rx_i,
	output logic            tx_o,
	output logic            rx_low_o
);
	logic [7:0] cnt_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_reg <= 8'h00;
		else if (send_i)
			cnt_reg <= len_i;
		else if (cnt_reg != 8'h00)
			cnt_reg <= cnt_reg - 8'h01;
	end
	// idle is recessive so a dropped request never locks the bus
	assign tx_o = (cnt_reg == 8'h00);
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i)
			rx_low_o <= 1'b0;
		else if (!rx_i)
			rx_low_o <= 1'b1;
	end
endmodule

// ===== testbench/can_phy_chk_sva.sv
`timescale 1ns/1ps
module can_phy_chk
	import canphy_pkg::*;
(
	// clock and reset
	input wire logic         clk_i,
	input wire logic         rst_i,
	// watched pins
	input wire logic         phy_tx_input_i,
	input wire logic         phy_rx_output_o,
	input wire logic         bus_dominant_i,
	input wire bus_monitor_t monitor_i,
	input wire tx_drive_t    tx_drive_o,
	input wire logic         reduced_performance_mode_i,
	input wire logic         stop_request_i
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_stop;
		reduced_performance_mode_i && stop_request_i;
	endsequence
	sequence s_hoc;
		tx_drive_o.dom_drive && monitor_i.high_overcurrent;
	endsequence
	sequence s_loc;
		tx_drive_o.dom_drive && monitor_i.low_overcurrent;
	endsequence
	AST_RESET_IDLE: assert property (disable iff (1'b0) rst_i |=> tx_drive_o == 3'h0 && phy_rx_output_o)
		else $error("drive or rx active after reset");
	AST_DOM_BOTH: assert property (tx_drive_o.dom_drive |-> tx_drive_o.high_drv_en)
		else $error("dominant without high driver");
	AST_LOW_NEEDS_HIGH: assert property (tx_drive_o.low_drv_en |-> tx_drive_o.high_drv_en)
		else $error("low driver alone");
	AST_DOM_FOLLOWS_TX: assert property (tx_drive_o.dom_drive |-> !$past(phy_tx_input_i, 3))
		else $error("dominant drive without tx request");
	// wake path owns rx while in standby, which is entered only in reduced performance
	AST_RX_FOLLOWS_BUS: assert property (!phy_rx_output_o && !reduced_performance_mode_i &&
		!$past(reduced_performance_mode_i, 8) |-> $past(bus_dominant_i, 3))
		else $error("rx low on recessive bus");
	AST_HV_LISTEN: assert property (monitor_i.hi_voltage_fail [*8] |-> tx_drive_o == 3'h0)
		else $error("transmitter on during voltage fail");
	AST_LUV_PSEUDO: assert property (monitor_i.low_line_undervoltage_status [*8] |-> !tx_drive_o.low_drv_en)
		else $error("low driver on during undervoltage");
	AST_HOC_OFF: assert property (s_hoc [*2] |-> ##[1:8] tx_drive_o == 3'h0)
		else $error("high overcurrent left driver on");
	AST_LOC_OFF: assert property (s_loc [*2] |-> ##[1:8] tx_drive_o == 3'h0)
		else $error("low overcurrent left driver on");
	AST_STANDBY_OFF: assert property (s_stop [*8] |-> tx_drive_o == 3'h0)
		else $error("driver on in standby");
endmodule
bind can_phy_mode_fault_control can_phy_chk u_chk (.clk_i, .rst_i, .phy_tx_input_i, .phy_rx_output_o,
	.bus_dominant_i, .monitor_i, .tx_drive_o, .reduced_performance_mode_i, .stop_request_i);

// ===== testbench/can_phy_mode_fault_control_tb.sv
`timescale 1ns/1ps
`include "canphy_defines.svh"
module can_phy_mode_fault_control_tb
	import canphy_pkg::*;
;
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic         cyc = 1'b0;
	logic         stb = 1'b0;
	logic         we = 1'b0;
	logic [7:0]   adr = 8'h00;
	logic [3:0]   sel = 4'h0;
	logic [31:0]  dat = 32'h0;
	logic [31:0]  dat_o;
	logic         ack_o;
	logic         tx;
	logic         rx;
	logic         bus = 1'b0;
	logic         wake = 1'b0;
	bus_monitor_t mon = 5'h00;
	tx_drive_t    drv;
	logic         reduced_performance_mode = 1'b0;
	logic         stop = 1'b0;
	logic         send = 1'b0;
	logic [7:0]   len = 8'h00;
	logic         clr = 1'b0;
	logic         rx_low;
	logic [31:0]  seed = 32'h55;
	logic [31:0]  q;
	logic [31:0]  r;
	int           n_fail = 0;
	int           samples_checked = 0;
	int           ncyc = 0;

	initial forever #2.5 clk_i = ~clk_i;

	can_phy_mode_fault_control #(.DT_CYCLES(32'h40)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.phy_tx_input_i(tx), .phy_rx_output_o(rx), .bus_dominant_i(bus), .wake_rx_dominant_i(wake),
		.monitor_i(mon), .tx_drive_o(drv), .reduced_performance_mode_i(reduced_performance_mode), .stop_request_i(stop));
	can_ctrl_model u_ctrl (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .len_i(len), .clr_i(clr),
		.rx_i(rx), .tx_o(tx), .rx_low_o(rx_low));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// wake events hidden from the controller per filter setting
	function automatic int msk(input logic [1:0] s);
		return s == 2'h0 ? 3 : s == 2'h1 ? 1 : s == 2'h2 ? 0 : 2;
	endfunction
	task automatic end_of_test();
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic mode(input logic [2:0] e);
		wb(1'b0, `ADDR_STATUS, 32'h0);
		chk(q & 32'h7, {29'h0, e});
	endtask
	task automatic snd(input logic [7:0] n);
		@(posedge clk_i);
		send <= 1'b1;
		len <= n;
		@(posedge clk_i);
		send <= 1'b0;
	endtask

	always @(posedge clk_i) begin
		ncyc <= ncyc + 1;
		if (ncyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end

	initial begin
		w(10);
		rst_i <= 1'b0;
		wb(1'b0, `ADDR_FAULT_FLAGS, 32'h0);
		chk(q, `FLAGS_RESET);
		mode(3'h0);
		snd(8'h14);
		w(8);
		chk({29'h0, drv}, 32'h0);
		wb(1'b1, 8'h10, 32'hffffffff);
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, `ADDR_CONTROL, 32'h1);
		w(250);
		mode(3'h1);
		for (int i = 0; i < 16; i++) begin
			r = rnd();
			bus <= r[0];
			snd({3'h0, r[5:1]} + 8'h08);
			w(7);
			chk({29'h0, drv}, 32'h7);
			chk({31'h0, rx}, {31'h0, ~r[0]});
			w(45);
			chk({29'h0, drv}, 32'h0);
		end
		bus <= 1'b0;
		snd(8'hff);
		w(100);
		wb(1'b0, `ADDR_FAULT_FLAGS, 32'h0);
		chk(q, 32'h8);
		mode(3'h3);
		chk({29'h0, drv}, 32'h0);
		wb(1'b1, `ADDR_FAULT_FLAGS, 32'h8);
		w(500);
		wb(1'b0, `ADDR_FAULT_FLAGS, 32'h0);
		chk(q, 32'h8);
		mode(3'h3);
		do wb(1'b0, `ADDR_STATUS, 32'h0); while (q[3] !== 1'b0);
		wb(1'b1, `ADDR_FAULT_FLAGS, 32'h8);
		w(150);
		mode(3'h3);
		w(150);
		mode(3'h1);
		for (int b = 2; b < 5; b++) begin
			mon <= 5'h01 << b;
			w(10);
			mode(b == 4 ? 3'h3 : b == 3 ? 3'h2 : 3'h1);
			snd(8'h14);
			w(8);
			chk({29'h0, drv}, b == 4 ? 32'h0 : b == 3 ? 32'h6 : 32'h7);
			mon <= 5'h00;
			w(30);
			mode(3'h1);
		end
		for (int b = 0; b < 2; b++) begin
			snd(8'h14);
			w(6);
			mon <= 5'h01 << b;
			w(6);
			mon <= 5'h00;
			w(30);
			wb(1'b0, `ADDR_FAULT_FLAGS, 32'h0);
			chk(q, 32'h1 << b);
			wb(1'b1, `ADDR_FAULT_FLAGS, 32'h0);
			mode(3'h3);
			wb(1'b1, `ADDR_FAULT_FLAGS, 32'h1 << b);
			w(10);
			mode(3'h1);
		end
		for (int s = 0; s < 4; s++) begin
			wb(1'b1, `ADDR_CONTROL, {29'h0, s[1:0], s[0]});
			reduced_performance_mode <= 1'b1;
			stop <= 1'b1;
			w(10);
			mode(3'h4);
			for (int k = 0; k < 3; k++) begin
				wake <= 1'b1;
				w(100);
				wake <= 1'b0;
				w(100);
				clr <= 1'b1;
				wake <= 1'b1;
				w(1);
				clr <= 1'b0;
				w(219);
				wake <= 1'b0;
				w(220);
				chk({31'h0, rx_low}, {31'h0, k >= msk(s[1:0])});
			end
			reduced_performance_mode <= 1'b0;
			stop <= 1'b0;
			w(10);
			mode(3'h1);
		end
		end_of_test();
	end
endmodule
